// [hdl/ssp_pkg.sv]
// Shared constants for the synthesizer serial programming port.
package ssp_pkg;

    // Serial word geometry.
    localparam int          SSP_WORD_W   = 22;
    localparam int          SSP_ADDR_W   = 2;
    localparam int          SSP_NWORDS   = 4;
    localparam logic [4:0]  SSP_LAST_BIT = 5'h15;

    // Control word addresses (bits 1..0).
    localparam logic [1:0]  SSP_ADDR_IF_REF  = 2'h0;
    localparam logic [1:0]  SSP_ADDR_RF_REF  = 2'h1;
    localparam logic [1:0]  SSP_ADDR_IF_MAIN = 2'h2;
    localparam logic [1:0]  SSP_ADDR_RF_MAIN = 2'h3;

    // Word 00 (if_reference_word) fields.
    localparam int          SSP_DITH_HI  = 21;
    localparam int          SSP_DITH_LO  = 20;
    localparam logic [1:0]  SSP_DITH_ON  = 2'h2;
    localparam logic [1:0]  SSP_DITH_OFF = 2'h3;
    localparam int          SSP_IFR_HI   = 19;
    localparam int          SSP_IFR_LO   = 7;
    localparam int          SSP_LDS_HI   = 6;
    localparam int          SSP_LDS_LO   = 4;
    localparam int          SSP_IFC_HI   = 3;
    localparam int          SSP_IFC_LO   = 2;

    // Word 01 (rf_reference_word) fields.
    localparam int          SSP_ME_HI    = 21;
    localparam int          SSP_ME_LO    = 9;
    localparam int          SSP_RFR_HI   = 8;
    localparam int          SSP_RFR_LO   = 6;
    localparam int          SSP_PS_BIT   = 5;
    localparam int          SSP_RFC_HI   = 4;
    localparam int          SSP_RFC_LO   = 3;
    localparam int          SSP_RFZ_BIT  = 2;

    // Word 10 (if_main_divider_word) fields.
    localparam int          SSP_IFN_HI   = 21;
    localparam int          SSP_IFN_LO   = 5;
    localparam int          SSP_RFEN_BIT = 4;
    localparam int          SSP_IFEN_BIT = 3;
    localparam int          SSP_IFZ_BIT  = 2;

    // Word 11 (rf_main_divider_word) fields.
    localparam int          SSP_RFN_HI   = 21;
    localparam int          SSP_RFN_LO   = 10;
    localparam int          SSP_FN_HI    = 9;
    localparam int          SSP_FN_LO    = 2;

    // Divider limits.
    localparam logic [11:0] SSP_RFN_MIN16 = 12'h100;
    localparam logic [11:0] SSP_RFN_MIN8  = 12'h040;
    localparam logic [11:0] SSP_RFN_MAX8  = 12'h800;
    localparam logic [16:0] SSP_IFN_MIN   = 17'h00100;
    localparam logic [2:0]  SSP_RFR_MIN   = 3'h1;

    // Reset: both sections powered.
    localparam logic [SSP_NWORDS-1:0][SSP_WORD_W-1:0] SSP_WORD_RST = {
        22'h000000, 22'h000018, 22'h000000, 22'h000000
    };

    // Indicator multiplexer selections.
    localparam logic [2:0]  SSP_LD_RF_LOCK = 3'h0;
    localparam logic [2:0]  SSP_LD_IF_LOCK = 3'h1;
    localparam logic [2:0]  SSP_LD_RF_REF  = 3'h2;
    localparam logic [2:0]  SSP_LD_RF_MAIN = 3'h3;
    localparam logic [2:0]  SSP_LD_IF_REF  = 3'h4;
    localparam logic [2:0]  SSP_LD_IF_MAIN = 3'h5;
    localparam logic [2:0]  SSP_LD_BOTH    = 3'h6;

    // Host command registers and serial timing.
    localparam logic [3:0]  SSP_REG_DATA   = 4'h0;
    localparam logic [3:0]  SSP_REG_STATUS = 4'h4;
    localparam int          SSP_CLK_NS     = 10;
    localparam int          SSP_HALF_NS    = 80;
    localparam logic [3:0]  SSP_HALF_CYC   = 4'(SSP_HALF_NS / SSP_CLK_NS);

endpackage : ssp_pkg

// [hdl/ssp_link_if.sv]
// Three-wire serial link between the host controller and the synthesizer port.
`timescale 1ns/1ps
interface ssp_link_if;
    logic sclk;
    logic sdata;
    logic latch_strobe;

    modport host   (output sclk, output sdata, output latch_strobe);
    modport device (input sclk, input sdata, input latch_strobe);
endinterface : ssp_link_if

// [hdl/ssp_sync.sv]
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/1ps
module ssp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : ssp_sync

// [hdl/ssp_device.sv]
// Synthesizer end: serial receiver, four control words and their decode.
//
// Notes on behaviour
// - Strobe low from first clock through 22nd.
// - Words are 22 bits, MSB first.
// - Low two bits address one of four words.
// - Commit only on rising strobe.
// - Strobe rising with clock high discards word.
// - Strobe pulses between successive words.
// - Strobe may stay high after last word.
// - Words written independently, any order.
// - Indicator selection lives in word 00.
// - Word 00 bits 21..20: 10 dither, 11 not.
// - Controller writes dithering bits after power-up.
// - One bit picks RF prescaler; IF fixed.
// - RF divider 256..4095 or 64..2048.
// - IF main divider is 17 bits, from 256.
// - RF reference 1..7, IF reference 1..8192.
// - Each charge pump can go high impedance.
// - Indicator shows dividers or lock, high locked.
// - Sections powered separately, both on at reset.
// - Coarse fraction bits 9..2, 1/256 steps.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module ssp_device
    import ssp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    ssp_link_if.device       link,
    input  wire logic        rf_locked,
    input  wire logic        if_locked,
    input  wire logic        rf_ref_div_out,
    input  wire logic        rf_main_div_out,
    input  wire logic        if_ref_div_out,
    input  wire logic        if_main_div_out,
    output logic             word_committed,
    output logic             word_discarded,
    output logic [1:0]       committed_addr,
    output logic             dither_en,
    output logic [12:0]      if_ref_divider,
    output logic [1:0]       if_pump_current,
    output logic [12:0]      frac_fine_extender,
    output logic [2:0]       rf_ref_divider,
    output logic             prescaler_select,
    output logic [1:0]       rf_pump_current,
    output logic             rf_pump_hiz,
    output logic [16:0]      if_main_divider,
    output logic             rf_power_en,
    output logic             if_power_en,
    output logic             if_pump_hiz,
    output logic [11:0]      rf_main_divider,
    output logic [7:0]       frac_coarse,
    output logic             lock_indicator,
    output logic             config_valid
);

    logic                  sclk_s;
    logic                  sdata_s;
    logic                  strobe_s;
    logic                  sclk_d;
    logic                  strobe_d;
    logic [5:0]            loop_s;
    logic [SSP_WORD_W-1:0] shifter;
    logic [SSP_WORD_W-1:0] words [SSP_NWORDS];
    logic                  sclk_rise;
    logic                  strobe_rise;
    logic                  commit_ok;
    logic                  next_lock_indicator;
    logic                  next_config_valid;

    // Strobe flops reset to its idle high level, so reset makes no false rise.
    ssp_sync #(.W(3), .RST_VAL(3'h1)) u_link_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({link.sclk, link.sdata, link.latch_strobe}),
        .q    ({sclk_s, sdata_s, strobe_s})
    );

    // Loop monitor levels are asynchronous too.
    ssp_sync #(.W(6)) u_loop_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({if_main_div_out, if_ref_div_out, rf_main_div_out,
                rf_ref_div_out, if_locked, rf_locked}),
        .q    (loop_s)
    );

    // Previous samples for edge detection.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_d   <= 1'b0;
            strobe_d <= 1'b1;
        end
        else
        begin
            sclk_d   <= sclk_s;
            strobe_d <= strobe_s;
        end
    end

    assign sclk_rise   = sclk_s && !sclk_d;
    assign strobe_rise = strobe_s && !strobe_d;
    // A rise with the clock high marks a broken frame.
    assign commit_ok   = strobe_rise && !sclk_s;

    // A separate shifter keeps half-sent words out of the configuration.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shifter <= '0;
        end
        else if (sclk_rise)
        begin
            shifter <= {shifter[SSP_WORD_W-2:0], sdata_s};
        end
    end

    // The last 22 bits shifted before the strobe rise form the word.
    generate
        for (genvar i = 0; i < SSP_NWORDS; i++)
        begin : g_word
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    words[i] <= SSP_WORD_RST[i];
                end
                else if (commit_ok && shifter[SSP_ADDR_W-1:0] == 2'(i))
                begin
                    words[i] <= shifter;
                end
            end
        end
    endgenerate

    // One-cycle commit and discard pulses.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            word_committed <= 1'b0;
            word_discarded <= 1'b0;
            committed_addr <= 2'h0;
        end
        else
        begin
            word_committed <= commit_ok;
            word_discarded <= strobe_rise && sclk_s;
            if (commit_ok)
            begin
                committed_addr <= shifter[SSP_ADDR_W-1:0];
            end
        end
    end

    // Field decode straight from the word flops.
    assign if_ref_divider     = words[SSP_ADDR_IF_REF][SSP_IFR_HI:SSP_IFR_LO];
    assign if_pump_current    = words[SSP_ADDR_IF_REF][SSP_IFC_HI:SSP_IFC_LO];
    assign frac_fine_extender = words[SSP_ADDR_RF_REF][SSP_ME_HI:SSP_ME_LO];
    assign rf_ref_divider     = words[SSP_ADDR_RF_REF][SSP_RFR_HI:SSP_RFR_LO];
    assign prescaler_select   = words[SSP_ADDR_RF_REF][SSP_PS_BIT];
    assign rf_pump_current    = words[SSP_ADDR_RF_REF][SSP_RFC_HI:SSP_RFC_LO];
    assign rf_pump_hiz        = words[SSP_ADDR_RF_REF][SSP_RFZ_BIT];
    assign if_main_divider    = words[SSP_ADDR_IF_MAIN][SSP_IFN_HI:SSP_IFN_LO];
    assign rf_power_en        = words[SSP_ADDR_IF_MAIN][SSP_RFEN_BIT];
    assign if_power_en        = words[SSP_ADDR_IF_MAIN][SSP_IFEN_BIT];
    assign if_pump_hiz        = words[SSP_ADDR_IF_MAIN][SSP_IFZ_BIT];
    assign rf_main_divider    = words[SSP_ADDR_RF_MAIN][SSP_RFN_HI:SSP_RFN_LO];
    assign frac_coarse        = words[SSP_ADDR_RF_MAIN][SSP_FN_HI:SSP_FN_LO];

    // Indicator multiplexer; only word 00 steers it.
    always_comb
    begin
        case (words[SSP_ADDR_IF_REF][SSP_LDS_HI:SSP_LDS_LO])
            SSP_LD_RF_LOCK: next_lock_indicator = loop_s[0];
            SSP_LD_IF_LOCK: next_lock_indicator = loop_s[1];
            SSP_LD_RF_REF:  next_lock_indicator = loop_s[2];
            SSP_LD_RF_MAIN: next_lock_indicator = loop_s[3];
            SSP_LD_IF_REF:  next_lock_indicator = loop_s[4];
            SSP_LD_IF_MAIN: next_lock_indicator = loop_s[5];
            SSP_LD_BOTH:    next_lock_indicator = loop_s[0] && loop_s[1];
            default:        next_lock_indicator = 1'b0;
        endcase
    end

    // Ratio range check; IF reference code 0 means 8192, so all codes pass.
    always_comb
    begin
        next_config_valid = (rf_ref_divider >= SSP_RFR_MIN)
                         && (if_main_divider >= SSP_IFN_MIN);
        if (prescaler_select)
        begin
            next_config_valid = next_config_valid
                             && (rf_main_divider >= SSP_RFN_MIN16);
        end
        else
        begin
            next_config_valid = next_config_valid
                             && (rf_main_divider >= SSP_RFN_MIN8)
                             && (rf_main_divider <= SSP_RFN_MAX8);
        end
    end

    // Registered pin and status outputs.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_indicator <= 1'b0;
            config_valid   <= 1'b0;
            dither_en      <= 1'b0;
        end
        else
        begin
            lock_indicator <= next_lock_indicator;
            config_valid   <= next_config_valid;
            dither_en      <= (words[SSP_ADDR_IF_REF][SSP_DITH_HI:SSP_DITH_LO]
                               == SSP_DITH_ON);
        end
    end

endmodule : ssp_device

// [hdl/ssp_host.sv]
// Controller end: command registers and the serial word transmitter.
`timescale 1ns/1ps
module ssp_host
    import ssp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    ssp_link_if.host         link
);

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_LATCH} ssp_state_t;

    ssp_state_t            state;
    logic [SSP_WORD_W-1:0] tx_word;
    logic [4:0]            bit_idx;
    logic [3:0]            timer;
    logic                  busy;
    logic                  start;
    logic                  tick;

    assign busy  = (state != ST_IDLE);
    // Writes while a word is in flight are dropped; software polls busy.
    assign start = wr && (addr == SSP_REG_DATA) && !busy;
    assign tick  = (timer == 4'h1);

    // Read data stand one cycle after the strobe.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata <= 32'h00000000;
        end
        else if (rd && addr == SSP_REG_DATA)
        begin
            rdata <= {10'h000, tx_word};
        end
        else if (rd && addr == SSP_REG_STATUS)
        begin
            rdata <= {26'h0000000, bit_idx, busy};
        end
        else
        begin
            rdata <= 32'h00000000;
        end
    end

    // Half-period timer for the divided serial clock.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer <= 4'h0;
        end
        else if (start || (busy && tick))
        begin
            timer <= SSP_HALF_CYC;
        end
        else if (timer != 4'h0)
        begin
            timer <= timer - 4'h1;
        end
    end

    // Strobe low, 22 bits MSB first changing at clock fall, strobe up at clock low.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state             <= ST_IDLE;
            tx_word           <= '0;
            bit_idx           <= 5'h00;
            link.sclk         <= 1'b0;
            link.sdata        <= 1'b0;
            link.latch_strobe <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        tx_word           <= wdata[SSP_WORD_W-1:0];
                        bit_idx           <= 5'h00;
                        link.sdata        <= wdata[SSP_WORD_W-1];
                        link.latch_strobe <= 1'b0;
                        state             <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        state     <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b0;
                        if (bit_idx == SSP_LAST_BIT)
                        begin
                            state <= ST_LATCH;
                        end
                        else
                        begin
                            tx_word    <= {tx_word[SSP_WORD_W-2:0], 1'b0};
                            link.sdata <= tx_word[SSP_WORD_W-2];
                            bit_idx    <= bit_idx + 5'h01;
                            state      <= ST_LOW;
                        end
                    end
                end
                ST_LOW:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        state     <= ST_HIGH;
                    end
                end
                ST_LATCH:
                begin
                    if (tick)
                    begin
                        link.latch_strobe <= 1'b1;
                        state             <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : ssp_host

// [bench/ssp_link_chk.sv]
// Concurrent checks on the serial link and the receiving end's decode.
`timescale 1ns/1ps
module ssp_link_chk
    import ssp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        sclk,
    input wire logic        sdata,
    input wire logic        latch_strobe,
    input wire logic        word_committed,
    input wire logic        word_discarded,
    input wire logic [1:0]  committed_addr,
    input wire logic        dither_en,
    input wire logic [2:0]  rf_ref_divider,
    input wire logic        prescaler_select,
    input wire logic [16:0] if_main_divider,
    input wire logic        rf_power_en,
    input wire logic [11:0] rf_main_divider,
    input wire logic [7:0]  frac_coarse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    logic        sclk_q;
    logic [4:0]  bits;
    logic [21:0] shadow;
    logic [21:0] held;

    // Reference pulse count and shifter on raw link clock rises.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_q <= 1'b0;
            bits   <= 5'h00;
            shadow <= 22'h000000;
        end
        else
        begin
            sclk_q <= sclk;
            if (latch_strobe)
                bits <= 5'h00;
            else if (sclk && !sclk_q)
                bits <= bits + 5'h01;
            if (sclk && !sclk_q)
                shadow <= {shadow[20:0], sdata};
        end
    end

    // Word frozen at the strobe rise.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            held <= 22'h000000;
        else if ($rose(latch_strobe))
            held <= shadow;
    end

    sequence good_rise_s;
        $rose(latch_strobe) && !sclk;
    endsequence

    sequence commit_to_s(logic [1:0] a);
        word_committed && committed_addr == a;
    endsequence

    frame_bits_a: assert property ($rose(latch_strobe) |-> bits == 5'h16)
        else $error("wrong pulse count");
    rise_clk_low_a: assert property ($rose(latch_strobe) |-> !sclk)
        else $error("strobe rose with clock high");
    commit_delay_a: assert property (good_rise_s |-> ##[2:6] word_committed)
        else $error("no commit");
    commit_cause_a: assert property (word_committed |-> latch_strobe && $past(latch_strobe)
        && !word_discarded)
        else $error("bad commit cause");
    commit_addr_a: assert property (word_committed |-> committed_addr == held[1:0])
        else $error("commit address wrong");
    dither_dec_a: assert property (commit_to_s(SSP_ADDR_IF_REF) |=>
        dither_en == (held[21:20] == SSP_DITH_ON))
        else $error("dither decode wrong");
    rf_ref_dec_a: assert property (commit_to_s(SSP_ADDR_RF_REF) |=>
        prescaler_select == held[5] && rf_ref_divider == held[8:6])
        else $error("rf reference word decode wrong");
    if_main_dec_a: assert property (commit_to_s(SSP_ADDR_IF_MAIN) |=>
        if_main_divider == held[21:5] && rf_power_en == held[4])
        else $error("if main word decode wrong");
    rf_main_dec_a: assert property (commit_to_s(SSP_ADDR_RF_MAIN) |=>
        rf_main_divider == held[21:10] && frac_coarse == held[9:2])
        else $error("rf main word decode wrong");
endmodule : ssp_link_chk

// [bench/synth_serial_program_port_tb_top.sv]
// Self-checking bench for both ends of the serial port.
`timescale 1ns/1ps
module synth_serial_program_port_tb_top
    import ssp_pkg::*;
;
    logic        clk;
    logic        rstn;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        rf_locked;
    logic [3:0]  div_cnt = 4'h0;
    logic        word_committed, word_discarded, dither_en, prescaler_select, rf_pump_hiz;
    logic        rf_power_en, if_power_en, if_pump_hiz, lock_indicator, wc2, wd2, config_valid;
    logic [1:0]  committed_addr, if_pump_current, rf_pump_current;
    logic [2:0]  rf_ref_divider;
    logic [7:0]  frac_coarse;
    logic [11:0] rf_main_divider, rfn2;
    logic [12:0] if_ref_divider, frac_fine_extender;
    logic [16:0] if_main_divider;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n_commit = 0;
    int          n_commit2 = 0;
    int          n_discard2 = 0;

    ssp_link_if link ();
    // Link2 lets the bench break strobe timing.
    ssp_link_if link2 ();

    ssp_host u_ssp_host (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .link(link));
    ssp_device u_ssp_device (.clk, .rstn, .link(link), .rf_locked, .if_locked(div_cnt[3]),
        .rf_ref_div_out(div_cnt[0]), .rf_main_div_out(div_cnt[1]), .if_ref_div_out(div_cnt[2]),
        .if_main_div_out(div_cnt[3]), .word_committed, .word_discarded, .committed_addr,
        .dither_en, .if_ref_divider, .if_pump_current, .frac_fine_extender, .rf_ref_divider,
        .prescaler_select, .rf_pump_current, .rf_pump_hiz, .if_main_divider, .rf_power_en,
        .if_power_en, .if_pump_hiz, .rf_main_divider, .frac_coarse, .lock_indicator,
        .config_valid);
    ssp_device u_ssp_device_2 (.clk, .rstn, .link(link2), .rf_locked, .if_locked(div_cnt[3]),
        .rf_ref_div_out(div_cnt[0]), .rf_main_div_out(div_cnt[1]), .if_ref_div_out(div_cnt[2]),
        .if_main_div_out(div_cnt[3]), .word_committed(wc2), .word_discarded(wd2),
        .committed_addr(), .dither_en(), .if_ref_divider(), .if_pump_current(),
        .frac_fine_extender(), .rf_ref_divider(), .prescaler_select(), .rf_pump_current(),
        .rf_pump_hiz(), .if_main_divider(), .rf_power_en(), .if_power_en(), .if_pump_hiz(),
        .rf_main_divider(rfn2), .frac_coarse(), .lock_indicator(), .config_valid());
    ssp_link_chk u_chk (.clk, .rstn, .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe), .word_committed, .word_discarded, .committed_addr,
        .dither_en, .rf_ref_divider, .prescaler_select, .if_main_divider, .rf_power_en,
        .rf_main_divider, .frac_coarse);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Event counters, divider toggles and the run limit.
    always @(posedge clk)
    begin
        div_cnt <= div_cnt + 4'h1;
        cycles <= cycles + 1;
        n_commit <= n_commit + int'(word_committed === 1'b1);
        n_commit2 <= n_commit2 + int'(wc2 === 1'b1);
        n_discard2 <= n_discard2 + int'(wd2 === 1'b1);
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s: %0h exp %0h", $time, what, seen, exp);
        end
    endtask : check

    // Bus tasks start just after a rising edge.
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : reg_rd

    // One word via the controller; poke writes again while busy.
    task automatic send(input logic [21:0] w, input logic poke);
        logic [31:0] st;
        int          n;
        n = n_commit;
        reg_wr(SSP_REG_DATA, {10'h000, w});
        reg_rd(SSP_REG_STATUS, st);
        check(st[0], 1'b1, "busy");
        if (poke)
            reg_wr(SSP_REG_DATA, 32'h00000002);
        for (int i = 0; i < 600 && n_commit == n; i++)
            @(posedge clk);
        check(committed_addr, w[1:0], "addr");
        for (int i = 0; i < 100 && st[0] !== 1'b0; i++)
            reg_rd(SSP_REG_STATUS, st);
        repeat (12) @(posedge clk);
        check(n_commit, n + 1, "commits");
        check(st[0], 1'b0, "idle");
    endtask : send

    // Frame on link2: mode 1 strobes with clock high, mode 2 never strobes.
    task automatic frame2(input logic [21:0] w, input logic [1:0] mode);
        link2.latch_strobe <= 1'b0;
        for (int i = 21; i >= 0; i--)
        begin
            link2.sdata <= w[i];
            repeat (SSP_HALF_CYC) @(posedge clk);
            link2.sclk <= 1'b1;
            repeat (SSP_HALF_CYC) @(posedge clk);
            if (i > 0 || mode != 2'h1)
                link2.sclk <= 1'b0;
        end
        link2.sdata <= ~w[0];
        repeat (SSP_HALF_CYC) @(posedge clk);
        if (mode != 2'h2)
            link2.latch_strobe <= 1'b1;
        repeat (SSP_HALF_CYC) @(posedge clk);
        link2.sclk <= 1'b0;
    endtask : frame2

    task automatic t_reset;
        logic [31:0] d;
        check({rf_power_en, if_power_en}, 2'h3, "power rst");
        reg_rd(4'h8, d);
        check(d, 32'h00000000, "unmapped rd");
        reg_wr(4'hC, 32'h003FFFFF);
        repeat (40) @(posedge clk);
        check(link.latch_strobe, 1'b1, "link idle");
        check(n_commit, 0, "no commit");
    endtask : t_reset

    task automatic t_words;
        send({12'h12D, 8'h86, SSP_ADDR_RF_MAIN}, 1'b1);
        send({13'h0CCC, 3'h7, 1'b0, 2'h1, 1'b1, SSP_ADDR_RF_REF}, 1'b0);
        send({17'h1FFFF, 1'b0, 1'b1, 1'b1, SSP_ADDR_IF_MAIN}, 1'b0);
        send({SSP_DITH_ON, 13'h1555, 3'h7, 2'h2, SSP_ADDR_IF_REF}, 1'b0);
        repeat (6) @(posedge clk);
        check(dither_en, 1'b1, "dither on");
        check(if_ref_divider, 13'h1555, "if ref");
        check(lock_indicator, 1'b0, "ind low");
        check(frac_fine_extender, 13'h0CCC, "fine");
        check({prescaler_select, rf_ref_divider}, 4'h7, "rf ref");
        check({rf_pump_hiz, if_pump_hiz}, 2'h3, "hiz");
        check({rf_power_en, if_power_en}, 2'h1, "power");
        check(if_main_divider, 17'h1FFFF, "if main");
        check({rf_main_divider, frac_coarse}, 20'h12D86, "rf main");
        check({if_pump_current, rf_pump_current, config_valid}, 5'h13, "pumps");
    endtask : t_words

    task automatic t_retarget;
        send({SSP_DITH_OFF, 13'h1555, SSP_LD_RF_LOCK, 2'h2, SSP_ADDR_IF_REF}, 1'b0);
        rf_locked <= 1'b1;
        repeat (8) @(posedge clk);
        check(lock_indicator, 1'b1, "locked");
        rf_locked <= 1'b0;
        repeat (8) @(posedge clk);
        check(lock_indicator, 1'b0, "unlocked");
        check(dither_en, 1'b0, "dither off");
        check({rf_main_divider, frac_coarse}, 20'h12D86, "kept");
        check(if_main_divider, 17'h1FFFF, "kept");
    endtask : t_retarget

    task automatic t_wire;
        frame2({12'h040, 8'h01, SSP_ADDR_RF_MAIN}, 2'h1);
        repeat (10) @(posedge clk);
        check(n_discard2, 1, "discard");
        check(n_commit2, 0, "no commit");
        check(rfn2, 12'h000, "kept");
        frame2({12'h040, 8'h01, SSP_ADDR_RF_MAIN}, 2'h0);
        repeat (100) @(posedge clk);
        check(n_commit2, 1, "one commit");
        check(rfn2, 12'h040, "msb first");
        frame2({12'h7FF, 8'h01, SSP_ADDR_RF_MAIN}, 2'h2);
        repeat (20) @(posedge clk);
        check(rfn2, 12'h040, "no rise");
        link2.latch_strobe <= 1'b1;
        repeat (10) @(posedge clk);
        check(rfn2, 12'h7FF, "late rise");
        check(n_commit2, 2, "commit count");
    endtask : t_wire

    task automatic close_out;
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // Reset, then the scenarios.
    initial
    begin
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        rf_locked = 1'b0;
        link2.sclk = 1'b0;
        link2.sdata = 1'b0;
        link2.latch_strobe = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_words();
        t_retarget();
        t_wire();
        close_out();
    end
endmodule : synth_serial_program_port_tb_top
